// *** design/bpio_pkg.sv ***
// constants for the bus/port i/o control block: register indexes, fields, resets.
// assumes a 5-bit register index bus with 8-bit data.
package bpio_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] IDX_UPPER_DATA = 5'h00;
  localparam logic [4:0] IDX_LOWER_DATA = 5'h01;
  localparam logic [4:0] IDX_UPPER_DIR = 5'h02;
  localparam logic [4:0] IDX_LOWER_DIR = 5'h03;
  localparam logic [4:0] IDX_CTRL_DATA = 5'h08;
  localparam logic [4:0] IDX_CTRL_DIR = 5'h09;
  localparam logic [4:0] IDX_FUNC_SEL = 5'h0a;
  localparam logic [4:0] IDX_PULLUP = 5'h0c;
  localparam logic [4:0] IDX_LOW_DRIVE = 5'h0d;
  localparam logic [4:0] IDX_EXPANSION_LIMIT = 5'h10;
  // function select fields, same positions as the control port pins they steer
  localparam int FS_DATA_BUS_ENABLE_DISABLE = 7;
  localparam int FS_CLOCK_MODULE_TEST_OUT = 6;
  localparam int FS_PIPE_STATUS_OUT_ENABLE = 5;
  localparam int FS_NO_E_CLOCK = 4;
  localparam int FS_LOW_STROBE_ENABLE = 3;
  localparam int FS_READ_WRITE_PIN_ENABLE = 2;
  localparam logic [7:0] FS_RST_NORMAL_SINGLE = 8'h90;
  localparam logic [7:0] FS_RST_SPECIAL_SINGLE = 8'h80;
  localparam logic [7:0] FS_RST_NORMAL_EXP = 8'h80;
  localparam logic [7:0] FS_RST_SPECIAL_EXP = 8'hac;
  localparam logic [7:0] FS_RST_PERIPHERAL = 8'h90;
  // pullup and reduced drive share one layout
  localparam int PU_CONTROL = 4;
  localparam int PU_LOWER = 1;
  localparam int PU_UPPER = 0;
  localparam logic [7:0] PU_MASK = 8'h13;
  localparam logic [7:0] PULLUP_RST = 8'h10;
  localparam logic [7:0] LOW_DRIVE_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] CTRL_OUT_MASK = 8'hfc;
  localparam logic [7:0] CTRL_PULLUP_MASK = 8'h8f;
  localparam logic [7:0] CTRL_ALWAYS_PULLUP = 8'h02;
  localparam logic [7:0] ALL_OUT_MASK = 8'hff;
  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } init_state_t;
endpackage

// *** design/bus_port_io_control.sv ***
// bus/port i/o control: two address/data ports and the bus-control port.
// assumes mode inputs are static straps and alternate signals come from
// the bus controller on the same clock.
module bus_port_io_control (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_ext_access,
  input wire logic i_mode_special,
  input wire logic i_mode_expanded,
  input wire logic i_mode_peripheral,
  input wire logic i_mode_narrow,
  input wire logic i_emulate_control_port,
  input wire logic i_internal_visibility,
  input wire logic i_e_clock_stretch,
  input wire logic i_tagging_on,
  input wire logic [15:0] i_bus_out,
  input wire logic i_bus_drive,
  input wire logic i_e_clock,
  input wire logic i_e_clock_fall,
  input wire logic i_read_write,
  input wire logic i_low_byte_strobe,
  input wire logic i_data_bus_enable,
  input wire logic [1:0] i_pipe_status,
  input wire logic i_clock_module_test,
  input wire logic [7:0] i_upper_pin_in,
  output logic [7:0] o_upper_pin_out,
  output logic [7:0] o_upper_pin_oe,
  output logic [7:0] o_upper_pullup,
  output logic o_upper_low_drive,
  input wire logic [7:0] i_lower_pin_in,
  output logic [7:0] o_lower_pin_out,
  output logic [7:0] o_lower_pin_oe,
  output logic [7:0] o_lower_pullup,
  output logic o_lower_low_drive,
  input wire logic [7:0] i_control_pin_in,
  output logic [7:0] o_control_pin_out,
  output logic [7:0] o_control_pin_oe,
  output logic [7:0] o_control_pullup,
  output logic o_control_low_drive,
  output logic o_low_byte_tag
);
  bpio_pkg::init_state_t state_ff;
  logic ready;
  logic single;
  logic normal_exp;
  logic bus_used;
  logic defined;
  logic is_ab;
  logic is_ctrl;
  logic removed;
  logic wr_ok;
  logic rd_ok;
  logic fs_wr;
  logic fs_acc;
  logic fs_written;
  logic no_e_clock_acc;
  logic ld_wr;
  logic ld_acc;
  logic [7:0] func_sel_ff;
  logic [7:0] nxt_func_sel;
  logic [7:0] fs_reset;
  logic [7:0] pullup_ff;
  logic [7:0] low_drive_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic tag_ff;
  logic nxt_tag;
  logic pipe_on;
  logic cgm_on;
  logic e_on;
  logic strobe_on;
  logic rw_on;
  logic [7:0] ctrl_sel;
  logic [7:0] upper_rd;
  logic [7:0] upper_dir;
  logic [7:0] lower_rd;
  logic [7:0] lower_dir;
  logic [7:0] ctrl_rd;
  logic [7:0] ctrl_dir;

  port_pins_if #(.W(8)) upper_if ();
  port_pins_if #(.W(8)) lower_if ();
  port_pins_if #(.W(8)) ctrl_if ();

  assign single = ~i_mode_expanded & ~i_mode_peripheral;
  assign normal_exp = i_mode_expanded & ~i_mode_special;
  // in peripheral mode an outside master owns the address/data pins too
  assign bus_used = i_mode_expanded | i_mode_peripheral;

  // the mode straps are only trusted once reset has released, so the
  // mode-dependent function select value is loaded in the first clocked cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= bpio_pkg::ST_LOAD;
    end else begin
      case (state_ff)
        bpio_pkg::ST_LOAD: state_ff <= bpio_pkg::ST_RUN;
        bpio_pkg::ST_RUN: state_ff <= bpio_pkg::ST_RUN;
        default: state_ff <= bpio_pkg::ST_LOAD;
      endcase
    end
  end

  assign ready = (state_ff == bpio_pkg::ST_RUN);

  always_comb begin
    defined = 1'b0;
    case (i_addr)
      bpio_pkg::IDX_UPPER_DATA,
      bpio_pkg::IDX_LOWER_DATA,
      bpio_pkg::IDX_UPPER_DIR,
      bpio_pkg::IDX_LOWER_DIR,
      bpio_pkg::IDX_CTRL_DATA,
      bpio_pkg::IDX_CTRL_DIR,
      bpio_pkg::IDX_FUNC_SEL,
      bpio_pkg::IDX_PULLUP,
      bpio_pkg::IDX_LOW_DRIVE: defined = 1'b1;
      default: defined = 1'b0;
    endcase
  end

  assign is_ab = (i_addr == bpio_pkg::IDX_UPPER_DATA) | (i_addr == bpio_pkg::IDX_LOWER_DATA)
               | (i_addr == bpio_pkg::IDX_UPPER_DIR) | (i_addr == bpio_pkg::IDX_LOWER_DIR);
  assign is_ctrl = (i_addr == bpio_pkg::IDX_CTRL_DATA) | (i_addr == bpio_pkg::IDX_CTRL_DIR);

  // every register of this block sits below the expansion limit, so
  // peripheral mode hides function select, pullup and drive as well
  assign removed = (i_mode_peripheral & (i_addr < bpio_pkg::IDX_EXPANSION_LIMIT))
                 | (i_mode_expanded & is_ab)
                 | (i_mode_expanded & i_emulate_control_port & is_ctrl);

  assign wr_ok = i_wr & ready & defined & ~removed;
  assign rd_ok = i_rd & ready & defined & ~removed;
  assign o_ext_access = (i_wr | i_rd) & ready & defined & removed;
  assign fs_wr = wr_ok & (i_addr == bpio_pkg::IDX_FUNC_SEL);
  assign ld_wr = wr_ok & (i_addr == bpio_pkg::IDX_LOW_DRIVE);

  write_gate #(.IGNORE_FIRST_SPECIAL(1'b1)) u_fs_gate (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_write(fs_wr),
    .i_special(i_mode_special),
    .o_accept(fs_acc),
    .o_written(fs_written)
  );

  write_gate #(.IGNORE_FIRST_SPECIAL(1'b0)) u_no_e_clock_gate (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_write(fs_wr),
    .i_special(i_mode_special),
    .o_accept(no_e_clock_acc),
    .o_written()
  );

  write_gate #(.IGNORE_FIRST_SPECIAL(1'b1)) u_ld_gate (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_write(ld_wr),
    .i_special(i_mode_special),
    .o_accept(ld_acc),
    .o_written()
  );

  always_comb begin
    if (i_mode_peripheral) begin
      fs_reset = bpio_pkg::FS_RST_PERIPHERAL;
    end else if (single) begin
      fs_reset = i_mode_special ? bpio_pkg::FS_RST_SPECIAL_SINGLE
                                : bpio_pkg::FS_RST_NORMAL_SINGLE;
    end else begin
      fs_reset = i_mode_special ? bpio_pkg::FS_RST_SPECIAL_EXP
                                : bpio_pkg::FS_RST_NORMAL_EXP;
    end
  end

  always_comb begin
    nxt_func_sel = func_sel_ff;
    if (!ready) begin
      nxt_func_sel = fs_reset;
    end else begin
      if (fs_acc) begin
        nxt_func_sel[7:5] = i_wdata[7:5];
        nxt_func_sel[3:2] = i_wdata[3:2];
      end
      if (no_e_clock_acc && single) begin
        nxt_func_sel[bpio_pkg::FS_NO_E_CLOCK] = i_wdata[bpio_pkg::FS_NO_E_CLOCK];
      end
    end
    // the external address is demultiplexed on e, so it cannot be turned off
    if (i_mode_expanded) begin
      nxt_func_sel[bpio_pkg::FS_NO_E_CLOCK] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      func_sel_ff <= bpio_pkg::FS_RST_NORMAL_SINGLE;
    end else begin
      func_sel_ff <= nxt_func_sel;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pullup_ff <= bpio_pkg::PULLUP_RST;
    end else if (wr_ok && i_addr == bpio_pkg::IDX_PULLUP) begin
      pullup_ff <= i_wdata & bpio_pkg::PU_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_drive_ff <= bpio_pkg::LOW_DRIVE_RST;
    end else if (ld_acc) begin
      low_drive_ff <= i_wdata & bpio_pkg::PU_MASK;
    end
  end

  // address/data ports: the bus controller owns drive and value when bus used
  assign upper_if.pin_in = i_upper_pin_in;
  assign upper_if.alt_sel = {8{bus_used}};
  assign upper_if.alt_out = i_bus_out[15:8];
  assign upper_if.alt_oe = {8{bus_used & i_bus_drive}};
  assign lower_if.pin_in = i_lower_pin_in;
  assign lower_if.alt_sel = {8{bus_used}};
  assign lower_if.alt_out = i_bus_out[7:0];
  assign lower_if.alt_oe = {8{bus_used & i_bus_drive}};

  // control port function resolution
  assign pipe_on = func_sel_ff[bpio_pkg::FS_PIPE_STATUS_OUT_ENABLE] & ~single;
  assign cgm_on = func_sel_ff[bpio_pkg::FS_CLOCK_MODULE_TEST_OUT]
                & ~single & ~normal_exp;
  assign e_on = ~func_sel_ff[bpio_pkg::FS_NO_E_CLOCK]
              & (~single | i_internal_visibility | ~i_e_clock_stretch);
  assign strobe_on = func_sel_ff[bpio_pkg::FS_LOW_STROBE_ENABLE]
                   & ~single & ~(normal_exp & i_mode_narrow);
  assign rw_on = func_sel_ff[bpio_pkg::FS_READ_WRITE_PIN_ENABLE] & ~single;

  assign ctrl_sel = {~func_sel_ff[bpio_pkg::FS_DATA_BUS_ENABLE_DISABLE],
                     pipe_on | cgm_on,
                     pipe_on,
                     e_on,
                     strobe_on,
                     rw_on,
                     2'b00};

  assign ctrl_if.pin_in = i_control_pin_in;
  assign ctrl_if.alt_sel = ctrl_sel;
  assign ctrl_if.alt_oe = ctrl_sel;
  // pipe status has priority over the clock module test signal on bit 6
  assign ctrl_if.alt_out = {i_data_bus_enable,
                            pipe_on ? i_pipe_status[1] : i_clock_module_test,
                            i_pipe_status[0],
                            i_e_clock,
                            i_low_byte_strobe,
                            i_read_write,
                            2'b00};

  gpio_slice #(.W(8), .OUT_MASK(bpio_pkg::ALL_OUT_MASK)) u_upper (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr_data(wr_ok && i_addr == bpio_pkg::IDX_UPPER_DATA),
    .i_wr_dir(wr_ok && i_addr == bpio_pkg::IDX_UPPER_DIR),
    .i_wdata(i_wdata),
    .pins(upper_if.slice),
    .o_data_rd(upper_rd),
    .o_dir_rd(upper_dir)
  );

  gpio_slice #(.W(8), .OUT_MASK(bpio_pkg::ALL_OUT_MASK)) u_lower (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr_data(wr_ok && i_addr == bpio_pkg::IDX_LOWER_DATA),
    .i_wr_dir(wr_ok && i_addr == bpio_pkg::IDX_LOWER_DIR),
    .i_wdata(i_wdata),
    .pins(lower_if.slice),
    .o_data_rd(lower_rd),
    .o_dir_rd(lower_dir)
  );

  gpio_slice #(.W(8), .OUT_MASK(bpio_pkg::CTRL_OUT_MASK)) u_ctrl (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr_data(wr_ok && i_addr == bpio_pkg::IDX_CTRL_DATA),
    .i_wr_dir(wr_ok && i_addr == bpio_pkg::IDX_CTRL_DIR),
    .i_wdata(i_wdata),
    .pins(ctrl_if.slice),
    .o_data_rd(ctrl_rd),
    .o_dir_rd(ctrl_dir)
  );

  assign o_upper_pin_out = upper_if.pin_out;
  assign o_upper_pin_oe = upper_if.pin_oe;
  assign o_lower_pin_out = lower_if.pin_out;
  assign o_lower_pin_oe = lower_if.pin_oe;
  assign o_control_pin_out = ctrl_if.pin_out;
  assign o_control_pin_oe = ctrl_if.pin_oe;

  assign o_upper_pullup = {8{pullup_ff[bpio_pkg::PU_UPPER] & ~bus_used}}
                        & ~upper_if.pin_oe;
  assign o_lower_pullup = {8{pullup_ff[bpio_pkg::PU_LOWER] & ~bus_used}}
                        & ~lower_if.pin_oe;
  assign o_control_pullup = ({8{pullup_ff[bpio_pkg::PU_CONTROL]}} & bpio_pkg::CTRL_PULLUP_MASK
                             & ~ctrl_if.pin_oe) | bpio_pkg::CTRL_ALWAYS_PULLUP;
  // reduced drive is per port and ignores which function the pin serves
  assign o_upper_low_drive = low_drive_ff[bpio_pkg::PU_UPPER];
  assign o_lower_low_drive = low_drive_ff[bpio_pkg::PU_LOWER];
  assign o_control_low_drive = low_drive_ff[bpio_pkg::PU_CONTROL];

  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_ok) begin
      case (i_addr)
        bpio_pkg::IDX_UPPER_DATA: nxt_rdata = upper_rd;
        bpio_pkg::IDX_LOWER_DATA: nxt_rdata = lower_rd;
        bpio_pkg::IDX_UPPER_DIR: nxt_rdata = upper_dir;
        bpio_pkg::IDX_LOWER_DIR: nxt_rdata = lower_dir;
        bpio_pkg::IDX_CTRL_DATA: nxt_rdata = ctrl_rd;
        bpio_pkg::IDX_CTRL_DIR: nxt_rdata = ctrl_dir;
        bpio_pkg::IDX_FUNC_SEL: nxt_rdata = func_sel_ff;
        bpio_pkg::IDX_PULLUP: nxt_rdata = pullup_ff;
        bpio_pkg::IDX_LOW_DRIVE: nxt_rdata = low_drive_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

  assign nxt_tag = i_mode_special & i_mode_expanded & strobe_on & i_tagging_on
                 & i_e_clock_fall & ~i_control_pin_in[3];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tag_ff <= 1'b0;
    end else begin
      tag_ff <= nxt_tag;
    end
  end

  assign o_low_byte_tag = tag_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_PERIPH_HIDES_LOW16: assert property (
    (i_mode_peripheral && i_rd && i_addr < bpio_pkg::IDX_EXPANSION_LIMIT)
    |=> o_rdata == 8'h00)
    else $error("peripheral mode read a hidden register");
  AST_EXP_AB_EXTERNAL: assert property (
    (ready && i_mode_expanded && (i_rd || i_wr) && is_ab) |-> o_ext_access && !wr_ok)
    else $error("address/data port register stayed on-chip");
  AST_EME_CTRL_EXTERNAL: assert property (
    (ready && i_mode_expanded && i_emulate_control_port && i_wr && is_ctrl)
    |-> o_ext_access ##1 $stable(ctrl_dir))
    else $error("control port register stayed on-chip");
  AST_UPPER_BUS: assert property (
    (bus_used && i_bus_drive) |-> o_upper_pin_oe == 8'hff
                               && o_upper_pin_out == i_bus_out[15:8])
    else $error("upper port not carrying bus high byte");
  AST_LOWER_BUS: assert property (
    (bus_used && !i_bus_drive) |-> o_lower_pin_oe == 8'h00)
    else $error("lower port drove while bus idle");
  AST_IRQ_PINS_INPUT: assert property (
    o_control_pin_oe[1:0] == 2'b00 && ctrl_dir[1:0] == 2'b00)
    else $error("interrupt pin can drive");
  AST_FS_RESET_MODE: assert property (
    (state_ff == bpio_pkg::ST_LOAD && i_mode_special && i_mode_expanded)
    |=> func_sel_ff == bpio_pkg::FS_RST_SPECIAL_EXP)
    else $error("function select reset value wrong for mode");
  AST_FS_ONCE_NORMAL: assert property (
    (fs_wr && !i_mode_special && fs_written)
    |=> func_sel_ff[7:5] == $past(func_sel_ff[7:5]))
    else $error("second normal-mode function select write accepted");
  AST_NO_ECLK_EXP: assert property (
    (i_mode_expanded && $past(i_mode_expanded) && ready) |-> !func_sel_ff[4] && e_on)
    else $error("e clock turned off in expanded mode");
  AST_E_PIN_SINGLE: assert property (
    (single && !func_sel_ff[4] && !i_e_clock_stretch)
    |-> o_control_pin_oe[4] && o_control_pin_out[4] == i_e_clock)
    else $error("e clock missing on single-chip pin");
  AST_TAG_PULSE: assert property (
    nxt_tag |=> o_low_byte_tag ##1 (o_low_byte_tag == $past(nxt_tag)))
    else $error("low byte tag not raised");
  AST_PULLUP_BUS_OFF: assert property (
    bus_used |-> o_upper_pullup == 8'h00 && o_lower_pullup == 8'h00)
    else $error("pullup active on bus port");

  COV_EXT_ACCESS: cover property (o_ext_access);
  COV_SPECIAL_SECOND_WRITE: cover property (fs_wr && i_mode_special && fs_acc);
  COV_TAG: cover property (o_low_byte_tag);
  COV_PIPE_OUT: cover property (pipe_on && o_control_pin_oe[6:5] == 2'b11);
endmodule // bus_port_io_control

// *** design/gpio_slice.sv ***
// one port: output latch, direction and pin mux.
// assumes the owner resolves alternate functions and drives pin_in.
module gpio_slice #(
  parameter int W = 8,
  parameter logic [W-1:0] OUT_MASK = '1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_data,
  input wire logic i_wr_dir,
  input wire logic [W-1:0] i_wdata,
  port_pins_if.slice pins,
  output logic [W-1:0] o_data_rd,
  output logic [W-1:0] o_dir_rd
);
  logic [W-1:0] latch_ff;
  logic [W-1:0] dir_ff;
  logic [W-1:0] gpio_out;

  if (W < 1 || W > 8) begin : g_bad_width
    $error("gpio_slice width must be 1 to 8");
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_ff <= '0;
    end else if (i_wr_data) begin
      latch_ff <= i_wdata;
    end
  end

  // pins that can never drive keep a zero direction bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_ff <= '0;
    end else if (i_wr_dir) begin
      dir_ff <= i_wdata & OUT_MASK;
    end
  end

  assign gpio_out = ~pins.alt_sel & dir_ff;
  assign pins.pin_out = (pins.alt_sel & pins.alt_out) | (~pins.alt_sel & latch_ff);
  assign pins.pin_oe = ((pins.alt_sel & pins.alt_oe) | gpio_out) & OUT_MASK;
  assign o_data_rd = (gpio_out & latch_ff) | (~gpio_out & pins.pin_in);
  assign o_dir_rd = dir_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_LATCH_KEEPS_WRITE: assert property (
    i_wr_data ##1 (!i_wr_data)[*2] |-> latch_ff == $past(i_wdata, 2))
    else $error("data latch lost a write");
  AST_DIR_DRIVES_PIN: assert property (
    (pins.alt_sel == '0) |-> (pins.pin_oe == (dir_ff & OUT_MASK))
                           && ((pins.pin_oe & pins.pin_out) == (pins.pin_oe & latch_ff)))
    else $error("direction bit does not set pin drive");
endmodule // gpio_slice

// *** design/port_pins_if.sv ***
// pin group carried between the top and one port slice.
// assumes the owner drives pin levels and alternate-function selects.
interface port_pins_if #(parameter int W = 8);
  logic [W-1:0] pin_in;
  logic [W-1:0] pin_out;
  logic [W-1:0] pin_oe;
  logic [W-1:0] alt_sel;
  logic [W-1:0] alt_out;
  logic [W-1:0] alt_oe;
  modport slice (input pin_in, alt_sel, alt_out, alt_oe, output pin_out, pin_oe);
  modport owner (output pin_in, alt_sel, alt_out, alt_oe, input pin_out, pin_oe);
endinterface

// *** design/write_gate.sv ***
// write-once / skip-first-write gate for a configuration register.
// assumes i_write is already qualified by the register being in the map.
module write_gate #(
  parameter bit IGNORE_FIRST_SPECIAL = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_write,
  input wire logic i_special,
  output logic o_accept,
  output logic o_written
);
  logic written_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      written_ff <= 1'b0;
    end else if (i_write) begin
      written_ff <= 1'b1;
    end
  end

  // an ignored first write still counts as the first one
  assign o_accept = i_write & (i_special ? (IGNORE_FIRST_SPECIAL ? written_ff : 1'b1)
                                         : ~written_ff);
  assign o_written = written_ff;
endmodule // write_gate

// *** verif/pin_partner.sv ***
// pin-side model: echoes driven pins, holds undriven pins at a fixed level.
// assumes one instance per 8-bit port.
module pin_partner #(parameter logic [7:0] LEVEL = 8'h3c) (
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  output logic [7:0] o_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_in = (i_oe & i_out) | (~i_oe & LEVEL);
endmodule // pin_partner

// *** verif/test_bus_port_io_control.sv ***
// bench for the bus/port i/o control block: normal single-chip, then special
// expanded and special peripheral straps after mid-run resets.
// assumes register indexes and reset values of bpio_pkg.
module test_bus_port_io_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, z = 0, i_e_clock = 1, i_data_bus_enable = 1;
  logic i_mode_special = 0, i_mode_expanded = 0, i_mode_peripheral = 0, i_bus_drive = 0;
  logic i_emulate_control_port = 0, i_tagging_on = 0, i_e_clock_fall = 0;
  logic o_ext_access, o_low_byte_tag, ext_v;
  logic [15:0] i_bus_out = '0;
  logic [4:0] i_addr = '0;
  logic [7:0] i_wdata = '0, o_rdata, rd_v, i_upper_pin_in, i_lower_pin_in, i_control_pin_in;
  logic [7:0] o_upper_pin_out, o_upper_pin_oe, o_upper_pullup, o_lower_pin_out, o_lower_pin_oe;
  logic [7:0] o_lower_pullup, o_control_pin_out, o_control_pin_oe, o_control_pullup;
  logic o_upper_low_drive, o_lower_low_drive, o_control_low_drive;
  int miscompares = 0, tests_run = 0, cycles = 0;
  bus_port_io_control uut (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_ext_access, .i_mode_special, .i_mode_expanded, .i_mode_peripheral,
    .i_mode_narrow(z), .i_emulate_control_port, .i_internal_visibility(z),
    .i_e_clock_stretch(z), .i_tagging_on, .i_bus_out, .i_bus_drive,
    .i_e_clock, .i_e_clock_fall, .i_read_write(z), .i_low_byte_strobe(z),
    .i_data_bus_enable, .i_pipe_status(2'b00), .i_clock_module_test(z), .i_upper_pin_in,
    .o_upper_pin_out, .o_upper_pin_oe, .o_upper_pullup, .o_upper_low_drive, .i_lower_pin_in,
    .o_lower_pin_out, .o_lower_pin_oe, .o_lower_pullup, .o_lower_low_drive, .i_control_pin_in,
    .o_control_pin_out, .o_control_pin_oe, .o_control_pullup, .o_control_low_drive,
    .o_low_byte_tag);
  pin_partner up (.i_out(o_upper_pin_out), .i_oe(o_upper_pin_oe), .o_in(i_upper_pin_in));
  pin_partner lo (.i_out(o_lower_pin_out), .i_oe(o_lower_pin_oe), .o_in(i_lower_pin_in));
  pin_partner ct (.i_out(o_control_pin_out), .i_oe(o_control_pin_oe), .o_in(i_control_pin_in));
  initial forever #20 i_clk = ~i_clk;
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    ext_v = o_ext_access;
    i_rd <= 1'b0;
    #1 rd_v = o_rdata;
  endtask
  // straps are levels, so they change only while reset is held
  task automatic restart(input logic sp, input logic ex, input logic pe);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    i_mode_special <= sp;
    i_mode_expanded <= ex;
    i_mode_peripheral <= pe;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // bound well above the roughly 64 cycles the sequence needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rd(bpio_pkg::IDX_FUNC_SEL);
    chk(rd_v, 8'h90);
    rd(bpio_pkg::IDX_PULLUP);
    chk(rd_v, 8'h10);
    chk(o_control_pullup, 8'h8f);
    $display("reset values done");
    wr(bpio_pkg::IDX_UPPER_DATA, 8'ha5);
    chk(o_upper_pin_oe, 8'h00);
    rd(bpio_pkg::IDX_UPPER_DATA);
    chk(rd_v, 8'h3c);
    wr(bpio_pkg::IDX_UPPER_DIR, 8'hf0);
    chk(o_upper_pin_oe, 8'hf0);
    chk(o_upper_pin_out & 8'hf0, 8'ha0);
    rd(bpio_pkg::IDX_UPPER_DATA);
    chk(rd_v, 8'hac);
    rd(5'h1f);
    chk(rd_v, 8'h00);
    chk({7'h00, ext_v}, 8'h00);
    $display("gpio done");
    wr(bpio_pkg::IDX_PULLUP, 8'h03);
    chk(o_control_pullup, 8'h02);
    chk(o_upper_pullup, 8'h0f);
    chk(o_lower_pullup, 8'hff);
    $display("pullups done");
    wr(bpio_pkg::IDX_CTRL_DIR, 8'hff);
    chk(o_control_pin_oe, 8'hfc);
    rd(bpio_pkg::IDX_CTRL_DIR);
    chk(rd_v, 8'hfc);
    $display("control port done");
    wr(bpio_pkg::IDX_FUNC_SEL, 8'h00);
    chk({7'h00, o_control_pin_oe[4]}, 8'h01);
    chk(o_control_pin_out & 8'h90, 8'h90);
    wr(bpio_pkg::IDX_FUNC_SEL, 8'hff);
    rd(bpio_pkg::IDX_FUNC_SEL);
    chk(rd_v, 8'h00);
    $display("function select done");
    wr(bpio_pkg::IDX_LOW_DRIVE, 8'h13);
    wr(bpio_pkg::IDX_LOW_DRIVE, 8'h00);
    chk({5'h00, o_upper_low_drive, o_lower_low_drive, o_control_low_drive}, 8'h07);
    $display("reduced drive done");
    i_emulate_control_port <= 1'b1;
    i_bus_out <= 16'h5a3c;
    i_bus_drive <= 1'b1;
    restart(1'b1, 1'b1, 1'b0);
    rd(bpio_pkg::IDX_FUNC_SEL);
    chk(rd_v, 8'hac);
    chk(o_control_pin_oe, 8'h7c);
    chk(o_upper_pin_out, 8'h5a);
    chk(o_lower_pin_out, 8'h3c);
    rd(bpio_pkg::IDX_UPPER_DIR);
    chk(rd_v, 8'h00);
    chk({7'h00, ext_v}, 8'h01);
    rd(bpio_pkg::IDX_CTRL_DIR);
    chk({7'h00, ext_v}, 8'h01);
    @(posedge i_clk);
    i_tagging_on <= 1'b1;
    i_e_clock_fall <= 1'b1;
    @(posedge i_clk);
    i_e_clock_fall <= 1'b0;
    #1 chk({7'h00, o_low_byte_tag}, 8'h01);
    @(posedge i_clk);
    #1 chk({7'h00, o_low_byte_tag}, 8'h00);
    wr(bpio_pkg::IDX_FUNC_SEL, 8'hff);
    rd(bpio_pkg::IDX_FUNC_SEL);
    chk(rd_v, 8'hac);
    wr(bpio_pkg::IDX_FUNC_SEL, 8'h10);
    rd(bpio_pkg::IDX_FUNC_SEL);
    chk(rd_v, 8'h00);
    chk(o_control_pin_oe, 8'h90);
    $display("special expanded done");
    restart(1'b1, 1'b0, 1'b1);
    rd(bpio_pkg::IDX_PULLUP);
    chk(rd_v, 8'h00);
    chk({7'h00, ext_v}, 8'h01);
    rd(bpio_pkg::IDX_CTRL_DATA);
    chk({7'h00, ext_v}, 8'h01);
    $display("peripheral done");
    finish_test();
  end
endmodule // test_bus_port_io_control
